// ---- dcomr_ctrl_model.sv ----
`timescale 1ns/1ps
module dcomr_ctrl_model (
   input wire logic link_clk_i, // Link clock.
   output logic cmd_valid_o, // Command strobe.
   output dcomr_pkg::dcomr_cmd_t cmd_o // Command fields.
);
   import dcomr_pkg::*;
   // Idle bus at time zero.
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   // One write or read per call; fields are inverted once released, so late sampling shows.
   task automatic send(input logic rd, input logic [5:0] a, input logic [7:0] d);
      @(posedge link_clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_o = '{is_read: rd, addr: a, op: d};
      @(posedge link_clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_o = ~cmd_o;
   endtask
endmodule

// ---- dcomr_link_capture.sv ----
`timescale 1ns/1ps
module dcomr_link_capture (
   input wire logic link_clk_i, // Command/address clock from the controller.
   input wire logic nrst_i, // Core reset, active low, synchronised here.
   input wire logic cmd_valid_i, // One-cycle command strobe on the link.
   input wire dcomr_pkg::dcomr_cmd_t cmd_i, // Command fields on the link.
   output logic toggle_o, // Flips once per captured command.
   output dcomr_pkg::dcomr_cmd_t cmd_o // Held command, stable until the next one.
);
   import dcomr_pkg::*;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic toggle;
      dcomr_cmd_t cmd;
   } dcomr_link_state_t;

   dcomr_link_state_t s_q;
   dcomr_link_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // The command is held in a register and announced by a toggle, so the core
   // reads stable fields once the toggle has crossed. Reset comes through two
   // flops because the link clock may only run while commands are sent.
   always_comb begin
      s_d = s_q;
      s_d.rst_sync = {s_q.rst_sync[0], nrst_i};
      if (!s_q.rst_sync[1]) begin
         s_d.toggle = 1'b0;
         s_d.cmd = '0;
      end else if (cmd_valid_i) begin
         s_d.cmd = cmd_i; // [R19]
         s_d.toggle = ~s_q.toggle;
      end
   end

   // State register.
   always_ff @(posedge link_clk_i) begin
      s_q <= s_d;
   end

   assign toggle_o = s_q.toggle;
   assign cmd_o = s_q.cmd;

endmodule

// ---- dcomr_mode_regs.sv ----
// Function
// R1: Write-only 8-bit upper-byte invert register at mode address 14H inverts per line.
// R2: Invert register resets to 55H.
// R3: Invert bits 0-3 drive lines 8-11, bits 4-7 drive lines 12-15.
// R4: Upper mask/inversion line always carries true pattern data.
// R5: No bus inversion during calibration readout, even when enabled.
// R6: Register 15H bit 5 selects low-speed command buffer, default normal.
// R7: Controller keeps clock at or below 800 MHz with low-speed buffer.
// R8: Controller sets low-speed bit only after initialization and other writes.
// R9: Controller enables low-speed buffer only with command termination disabled.
// R10: Without low-speed support the select bit write is ignored.
// R11: Two set-point copies; writes and reads reach the write set-point copy.
// R12: Device operates from the operating set-point copy only.
// R13: Register 16H bits 2-0 code controller termination; 000 off, 111 reserved.
// R14: Bit 3 set terminates clock inputs at programmed strength regardless of pad.
// R15: Bit 4 set terminates chip select at programmed strength regardless of pad.
// R16: Bit 5 clear terminates command lines only with pad high and valid strength.
// R17: Bit 5 set disables command line termination unconditionally.
// R18: Bond pad is ignored; termination depends on registers only.
// R19: Mode register writes latch the operand into the addressed copy.
`timescale 1ns/1ps
module dcomr_mode_regs #(
   parameter bit LOW_SPEED_SUPPORTED = 1'b1, // Low-speed buffer fitted.
   parameter bit BOND_PAD_IGNORED = 1'b1 // Pad has no effect in this family.
) (
   input wire logic core_clk_i, // Core clock, 10 MHz.
   input wire logic nrst_i, // Synchronous reset, active low.
   input wire logic link_clk_i, // Command/address clock from the controller.
   input wire logic cmd_valid_i, // Command strobe, link domain.
   input wire dcomr_pkg::dcomr_cmd_t cmd_i, // Command fields, link domain.
   input wire logic term_bond_pad_i, // Termination bond pad level, asynchronous.
   input wire logic calib_active_i, // Calibration pattern readout in progress.
   input wire logic calib_pat_bit_i, // Current calibration pattern bit.
   input wire logic [7:0] rd_data_i, // Upper-byte read data, normal reads.
   input wire logic rd_dbi_flag_i, // Byte would be sent inverted under BUS_INVERSION.
   output logic [7:0] dq_upper_o, // Upper-byte data lines 15..8.
   output logic mask_inversion_line_o, // Upper mask/inversion line.
   output dcomr_pkg::dcomr_term_t term_o, // Termination controls.
   output logic low_speed_buf_o, // Low-speed command buffer selected.
   output logic [7:0] mrr_data_o, // Mode read answer.
   output logic mrr_valid_o // One-cycle pulse with mode read answer.
);
   import dcomr_pkg::*;

   typedef struct packed {
      logic [2:0] tog; // tog[0] is the first synchroniser flop.
      logic [1:0] pad; // pad[0] is the first synchroniser flop.
      logic [7:0] invert;
      logic [1:0] low_speed; // Indexed by set point.
      logic [1:0][5:0] term_ovr; // Indexed by set point.
      logic write_set_point_select;
      logic operating_set_point_select;
      logic [2:0] strength;
      logic dbi_rd;
      logic [7:0] dq;
      logic mil;
      dcomr_term_t term;
      logic low_speed_buf;
      logic [7:0] mrr_data;
      logic mrr_valid;
   } dcomr_state_t;

   dcomr_state_t s_q;
   dcomr_state_t s_d;
   logic link_toggle;
   dcomr_cmd_t link_cmd;
   logic [7:0] calib_dq;
   logic cmd_seen;
   logic [5:0] op_term;
   logic op_low_speed;
   logic strength_valid;
   logic pad_high;

   ////////////////////////////////////////////////////////////////////////////
   // Link side capture; only a toggle and held fields cross into the core.
   dcomr_link_capture u_link (
      .link_clk_i(link_clk_i),
      .nrst_i(nrst_i),
      .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i),
      .toggle_o(link_toggle),
      .cmd_o(link_cmd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per-line calibration pattern: invert bit n drives data line 8+n.
   generate
      for (genvar n = 0; n < 8; n++) begin : g_calib
         assign calib_dq[n] = calib_pat_bit_i ^ s_q.invert[n]; // [R1] [R3]
      end
   endgenerate

   // A new command is seen when the synchronised toggle changes.
   assign cmd_seen = s_q.tog[2] ^ s_q.tog[1];

   // The operating copy alone steers the pads; the other may be rewritten freely.
   assign op_term = s_q.term_ovr[s_q.operating_set_point_select]; // [R12]
   assign op_low_speed = s_q.low_speed[s_q.operating_set_point_select]; // [R12]
   assign strength_valid = (s_q.strength != DCOMR_STR_DISABLED);
   assign pad_high = BOND_PAD_IGNORED | s_q.pad[1]; // [R18]

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block.
   always_comb begin
      s_d = s_q;
      s_d.tog = {s_q.tog[1:0], link_toggle};
      s_d.pad = {s_q.pad[0], term_bond_pad_i};
      s_d.mrr_valid = 1'b0;

      // Command decode. Fields are stable because they changed with the toggle, which takes two core edges to cross.
      if (cmd_seen) begin
         if (link_cmd.is_read) begin
            // Reads of set-point registers return the write set-point copy.
            s_d.mrr_valid = 1'b1;
            s_d.mrr_data = 8'h00;
            if (link_cmd.addr == DCOMR_MA_LOW_SPEED_BUF) begin
               s_d.mrr_data[DCOMR_BIT_LOW_SPEED] = s_q.low_speed[s_q.write_set_point_select]; // [R11]
            end else if (link_cmd.addr == DCOMR_MA_TERM_OVERRIDE) begin
               s_d.mrr_data[5:0] = s_q.term_ovr[s_q.write_set_point_select]; // [R11]
            end
         end else begin
            unique case (link_cmd.addr)
               DCOMR_MA_UPPER_INVERT: begin
                  s_d.invert = link_cmd.op; // [R1] [R19]
               end
               DCOMR_MA_LOW_SPEED_BUF: begin
                  // A part without the slow buffer keeps the bit at normal.
                  if (LOW_SPEED_SUPPORTED) begin // [R10]
                     s_d.low_speed[s_q.write_set_point_select] = link_cmd.op[DCOMR_BIT_LOW_SPEED]; // [R6] [R11]
                  end
               end
               DCOMR_MA_TERM_OVERRIDE: begin
                  s_d.term_ovr[s_q.write_set_point_select] = link_cmd.op[5:0]; // [R11] [R19]
               end
               DCOMR_MA_FREQ_SET_POINT: begin
                  s_d.write_set_point_select = link_cmd.op[DCOMR_BIT_WRITE_SET_POINT_SELECT];
                  s_d.operating_set_point_select = link_cmd.op[DCOMR_BIT_OPERATING_SET_POINT_SELECT];
               end
               DCOMR_MA_TERM_STRENGTH: begin
                  s_d.strength = link_cmd.op[DCOMR_STR_MSB:DCOMR_STR_LSB];
               end
               DCOMR_MA_IO_CONFIG: begin
                  s_d.dbi_rd = link_cmd.op[DCOMR_BIT_DBI_RD];
               end
               default: begin
               end
            endcase
         end
      end

      // Upper-byte data path: calibration readout never applies bus inversion.
      if (calib_active_i) begin
         s_d.dq = calib_dq; // [R5]
         s_d.mil = calib_pat_bit_i; // [R4]
      end else begin
         s_d.dq = (s_q.dbi_rd && rd_dbi_flag_i) ? ~rd_data_i : rd_data_i;
         s_d.mil = s_q.dbi_rd && rd_dbi_flag_i;
      end

      // Controller-side termination code; the reserved code is driven as off.
      if (op_term[DCOMR_SOC_MSB:0] == DCOMR_SOC_RESERVED) begin // [R13]
         s_d.term.soc_code = DCOMR_SOC_DISABLED;
      end else begin
         s_d.term.soc_code = op_term[DCOMR_SOC_MSB:0]; // [R13]
      end

      // Clock and chip select terminate with valid strength on override or on a high pad.
      s_d.term.ck_term = strength_valid && (op_term[DCOMR_BIT_CK_OVR] || pad_high); // [R14]
      s_d.term.cs_term = strength_valid && (op_term[DCOMR_BIT_CS_OVR] || pad_high); // [R15]
      // Command lines need pad and strength unless the disable bit wins.
      s_d.term.ca_term = !op_term[DCOMR_BIT_CA_DIS] && pad_high && strength_valid; // [R16] [R17]

      // The controller keeps command termination off while this is set.
      s_d.low_speed_buf = op_low_speed; // [R6] [R9]

      // Synchronous reset overrides everything.
      if (!nrst_i) begin
         s_d = '0;
         s_d.invert = DCOMR_INVERT_RESET; // [R2]
         s_d.term_ovr = {DCOMR_TERM_RESET, DCOMR_TERM_RESET};
         s_d.strength = DCOMR_STRENGTH_RESET;
      end
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   assign dq_upper_o = s_q.dq;
   assign mask_inversion_line_o = s_q.mil;
   assign term_o = s_q.term;
   assign low_speed_buf_o = s_q.low_speed_buf;
   assign mrr_data_o = s_q.mrr_data;
   assign mrr_valid_o = s_q.mrr_valid;

endmodule

// ---- dcomr_mode_regs_asserts.sv ----
`timescale 1ns/1ps
module dcomr_mode_regs_asserts #(
   parameter bit LOW_SPEED_SUPPORTED = 1'b1, // Buffer fitted.
   parameter bit BOND_PAD_IGNORED = 1'b1 // Pad unused.
) (
   input wire logic core_clk_i, // Core clock.
   input wire logic nrst_i, // Reset, active low.
   input wire logic link_clk_i, // Link clock.
   input wire logic cmd_valid_i, // Command strobe.
   input wire logic calib_active_i, // Calibration readout.
   input wire logic calib_pat_bit_i, // Pattern bit.
   input wire logic [7:0] dq_upper_o, // Data lines.
   input wire logic mask_inversion_line_o, // Mask line.
   input wire dcomr_pkg::dcomr_term_t term_o, // Termination.
   input wire logic low_speed_buf_o, // Low-speed buffer.
   input wire logic mrr_valid_o // Read pulse.
);
   import dcomr_pkg::*;
   logic tog_q;
   logic [2:0] sync_q;
   logic [3:0] quiet_q;
   // A level crosses safely where a 32 ns strobe could slip between core edges.
   always_ff @(posedge link_clk_i) begin
      if (!nrst_i) begin
         tog_q <= 1'b0;
      end else if (cmd_valid_i) begin
         tog_q <= ~tog_q;
      end
   end
   // Core cycles since a command reached the core, saturating.
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         sync_q <= 3'h0;
         quiet_q <= 4'h0;
      end else begin
         sync_q <= {sync_q[1:0], tog_q};
         quiet_q <= (sync_q[2] != sync_q[1]) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
      end
   end
   //////////////////////////////
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   a_mask_true: assert property ($past(calib_active_i) && $past(nrst_i)
      |-> mask_inversion_line_o == $past(calib_pat_bit_i)) else $error("mask line wrong");
   a_calib_track: assert property (quiet_q > 5 && $past(calib_active_i)
      && $past(calib_active_i, 2) |-> (dq_upper_o ^ $past(dq_upper_o))
      == {8{$past(calib_pat_bit_i) ^ $past(calib_pat_bit_i, 2)}}) else $error("calib dq wrong");
   a_soc_legal: assert property (term_o.soc_code != DCOMR_SOC_RESERVED)
      else $error("reserved code driven");
   a_ck_cs_pair: assert property (BOND_PAD_IGNORED
      |-> term_o.ck_term == term_o.cs_term) else $error("clock and select differ");
   a_ca_strength: assert property (BOND_PAD_IGNORED && term_o.ca_term
      |-> term_o.ck_term) else $error("command lines without strength");
   a_quiet_stable: assert property (quiet_q > 5
      |-> $stable(term_o) && $stable(low_speed_buf_o)) else $error("change without command");
   a_read_pulse: assert property (mrr_valid_o |=> !mrr_valid_o)
      else $error("read pulse too long");
   a_read_time: assert property (mrr_valid_o |-> quiet_q < 4)
      else $error("read answer late");
   a_reset_clear: assert property (disable iff (1'b0) !nrst_i
      |=> term_o == '0 && !mrr_valid_o && !low_speed_buf_o) else $error("reset not clean");
   c_read: cover property (mrr_valid_o);
   c_ca_term: cover property (term_o.ca_term);
   c_low_speed: cover property (low_speed_buf_o);
endmodule
bind dcomr_mode_regs dcomr_mode_regs_asserts #(.LOW_SPEED_SUPPORTED(LOW_SPEED_SUPPORTED),
   .BOND_PAD_IGNORED(BOND_PAD_IGNORED)) dcomr_mode_regs_asserts_inst (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i),
   .cmd_valid_i(cmd_valid_i), .calib_active_i(calib_active_i),
   .calib_pat_bit_i(calib_pat_bit_i), .dq_upper_o(dq_upper_o),
   .mask_inversion_line_o(mask_inversion_line_o), .term_o(term_o),
   .low_speed_buf_o(low_speed_buf_o), .mrr_valid_o(mrr_valid_o));

// ---- dcomr_mode_regs_tb_top.sv ----
`timescale 1ns/1ps
module dcomr_mode_regs_tb_top;
   import dcomr_pkg::*;
   logic core_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid_i;
   dcomr_cmd_t cmd_i;
   logic pad = 1'b0;
   logic calib = 1'b0;
   logic pat = 1'b0;
   logic flag = 1'b1;
   logic lsb_b;
   logic [7:0] dq;
   logic mask;
   dcomr_term_t term;
   logic lsb;
   logic [7:0] mode_register_read;
   logic mrr_v;
   logic [7:0] ops [7] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h07, 8'h05, 8'h1b};
   int err_total = 0;
   int checks_done = 0;
   //////////////////////////////
   // The link clock stays far below the low-speed ceiling, phase unrelated.
   initial forever #50 core_clk_i = ~core_clk_i;
   initial begin
      #7;
      forever #16 link_clk_i = ~link_clk_i;
   end
   dcomr_ctrl_model dcomr_ctrl_model_inst (.link_clk_i(link_clk_i), .cmd_valid_o(cmd_valid_i),
      .cmd_o(cmd_i));
   dcomr_mode_regs dcomr_mode_regs_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .term_bond_pad_i(pad),
      .calib_active_i(calib), .calib_pat_bit_i(pat), .rd_data_i(8'h3c), .rd_dbi_flag_i(flag),
      .dq_upper_o(dq), .mask_inversion_line_o(mask), .term_o(term), .low_speed_buf_o(lsb),
      .mrr_data_o(mode_register_read), .mrr_valid_o(mrr_v));
   // A part without the slow buffer sees the same command stream and must ignore 15H bit 5.
   dcomr_mode_regs #(.LOW_SPEED_SUPPORTED(1'b0)) dcomr_mode_regs_b_inst (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .term_bond_pad_i(pad), .calib_active_i(calib), .calib_pat_bit_i(pat), .rd_data_i(8'h3c),
      .rd_dbi_flag_i(flag), .dq_upper_o(), .mask_inversion_line_o(), .term_o(),
      .low_speed_buf_o(lsb_b), .mrr_data_o(), .mrr_valid_o());
   //////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Commands are spaced well beyond the minimum so each lands alone.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      dcomr_ctrl_model_inst.send(1'b0, a, d);
      repeat (12) @(negedge core_clk_i);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      dcomr_ctrl_model_inst.send(1'b1, a, 8'h00);
      while (mrr_v !== 1'b1 && n < 20) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      if (n == 20) begin
         err_total++;
         finish_test();
      end else begin
         check("read data", mode_register_read, exp);
         repeat (12) @(negedge core_clk_i);
      end
   endtask
   // Pad ignored, so only strength and override bits matter.
   function automatic logic [7:0] exp_term(input logic [7:0] op, input logic sv);
      logic [2:0] soc;
      soc = (op[2:0] == 3'h7) ? 3'h0 : op[2:0];
      return {2'h0, sv, sv, sv & ~op[5], soc};
   endfunction
   task automatic calib_chk(input logic [7:0] inv);
      for (int p = 0; p < 2; p++) begin
         pat = p[0];
         @(negedge core_clk_i);
         check("calib dq", dq, {8{p[0]}} ^ inv);
         check("mask line", {7'h0, mask}, {7'h0, p[0]});
      end
   endtask
   //////////////////////////////
   initial begin
      repeat (20) @(negedge core_clk_i);
      nrst_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      check("term reset", {2'h0, term}, 8'h00);
      check("low speed reset", {7'h0, lsb}, 8'h00);
      calib = 1'b1;
      calib_chk(8'h55);
      wr(DCOMR_MA_IO_CONFIG, 8'h40);
      wr(DCOMR_MA_UPPER_INVERT, 8'h0d);
      calib_chk(8'h0d);
      calib = 1'b0;
      @(negedge core_clk_i);
      check("dq normal", dq, 8'hc3);
      check("mask normal", {7'h0, mask}, 8'h01);
      flag = 1'b0;
      @(negedge core_clk_i);
      check("dq plain", dq, 8'h3c);
      check("mask plain", {7'h0, mask}, 8'h00);
      wr(DCOMR_MA_TERM_STRENGTH, 8'h10);
      foreach (ops[i]) begin
         wr(DCOMR_MA_TERM_OVERRIDE, ops[i]);
         pad = ~pad;
         repeat (3) @(negedge core_clk_i);
         check("term", {2'h0, term}, exp_term(ops[i], 1'b1));
      end
      wr(DCOMR_MA_TERM_STRENGTH, 8'h00);
      check("term no strength", {2'h0, term}, exp_term(8'h1b, 1'b0));
      wr(DCOMR_MA_TERM_STRENGTH, 8'h10);
      wr(DCOMR_MA_FREQ_SET_POINT, 8'h40);
      wr(DCOMR_MA_TERM_OVERRIDE, 8'h3f);
      check("term idle copy", {2'h0, term}, exp_term(8'h1b, 1'b1));
      rd(DCOMR_MA_TERM_OVERRIDE, 8'h3f);
      wr(DCOMR_MA_FREQ_SET_POINT, 8'h80);
      check("term copy one", {2'h0, term}, exp_term(8'h3f, 1'b1));
      rd(DCOMR_MA_TERM_OVERRIDE, 8'h1b);
      wr(DCOMR_MA_FREQ_SET_POINT, 8'h00);
      wr(DCOMR_MA_TERM_OVERRIDE, 8'h20);
      rd(DCOMR_MA_LOW_SPEED_BUF, 8'h00);
      // Low-speed buffer chosen last, with command termination already off.
      wr(DCOMR_MA_LOW_SPEED_BUF, 8'h20);
      check("low speed", {7'h0, lsb}, 8'h01);
      check("low speed absent", {7'h0, lsb_b}, 8'h00);
      rd(DCOMR_MA_LOW_SPEED_BUF, 8'h20);
      rd(6'h20, 8'h00);
      // A second reset in mid-run must bring back the power-on values.
      nrst_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      nrst_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      check("term again", {2'h0, term}, 8'h00);
      check("low speed again", {7'h0, lsb}, 8'h00);
      calib = 1'b1;
      calib_chk(8'h55);
      finish_test();
   end
endmodule

// ---- dcomr_pkg.sv ----
package dcomr_pkg;

   // Mode addresses carried by mode register write and read commands.
   localparam logic [5:0] DCOMR_MA_IO_CONFIG = 6'h03;
   localparam logic [5:0] DCOMR_MA_TERM_STRENGTH = 6'h0b;
   localparam logic [5:0] DCOMR_MA_FREQ_SET_POINT = 6'h0d;
   localparam logic [5:0] DCOMR_MA_UPPER_INVERT = 6'h14;
   localparam logic [5:0] DCOMR_MA_LOW_SPEED_BUF = 6'h15;
   localparam logic [5:0] DCOMR_MA_TERM_OVERRIDE = 6'h16;

   // Reset values.
   localparam logic [7:0] DCOMR_INVERT_RESET = 8'h55;
   localparam logic [5:0] DCOMR_TERM_RESET = 6'h00;
   localparam logic [2:0] DCOMR_STRENGTH_RESET = 3'h0;

   // Field positions inside the operand byte.
   localparam int DCOMR_BIT_DBI_RD = 6;
   localparam int DCOMR_BIT_WRITE_SET_POINT_SELECT = 6;
   localparam int DCOMR_BIT_OPERATING_SET_POINT_SELECT = 7;
   localparam int DCOMR_STR_LSB = 4;
   localparam int DCOMR_STR_MSB = 6;
   localparam int DCOMR_BIT_LOW_SPEED = 5;
   localparam int DCOMR_SOC_MSB = 2;
   localparam int DCOMR_BIT_CK_OVR = 3;
   localparam int DCOMR_BIT_CS_OVR = 4;
   localparam int DCOMR_BIT_CA_DIS = 5;

   // Termination codes.
   localparam logic [2:0] DCOMR_SOC_DISABLED = 3'h0;
   localparam logic [2:0] DCOMR_SOC_RESERVED = 3'h7;
   localparam logic [2:0] DCOMR_STR_DISABLED = 3'h0;

   // One command captured at the link: read or write, mode address, operand.
   typedef struct packed {
      logic is_read;
      logic [5:0] addr;
      logic [7:0] op;
   } dcomr_cmd_t;

   // Termination controls presented to the pad ring.
   typedef struct packed {
      logic ck_term;
      logic cs_term;
      logic ca_term;
      logic [2:0] soc_code;
   } dcomr_term_t;

endpackage
